// ===== tb/mgmt_link_chk.sv
// assertions on the management link wires, sampled on the link clock
`timescale 1ns/1ps
module mgmt_link_chk (
   // link clock and device reset
   input wire logic mdc,
   input wire logic rst,
   // link wires
   input wire logic sta_mdio_out,
   input wire logic sta_mdio_oe,
   input wire logic phy_mdio_out,
   input wire logic phy_mdio_oe,
   input wire logic mdio
);
   default clocking cb @(posedge mdc); endclocking
   default disable iff (rst);
   logic [4:0] drive_cnt;
   // length of the device drive burst; mdc halts in reset, so a burst never spans one
   always_ff @(posedge mdc or posedge rst) begin
      if (rst) begin
         drive_cnt <= 5'h00;
      end else begin
         drive_cnt <= phy_mdio_oe ? drive_cnt + 5'h01 : 5'h00;
      end
   end
   // start pattern as seen by the device
   sequence frame_open;
      $rose(sta_mdio_oe) && !mdio ##1 mdio;
   endsequence
   sequence op_read;
      mdio ##1 !mdio;
   endsequence
   sequence op_write;
      !mdio ##1 mdio;
   endsequence
   chk_no_clash: assert property (!(sta_mdio_oe && phy_mdio_oe))
      else $error("both ends drive the data wire");
   chk_start_code: assert property ($rose(sta_mdio_oe) |-> $past(mdio) && !mdio ##1 mdio)
      else $error("frame does not open with idle then 01");
   chk_op_legal: assert property (frame_open |-> ##2 (mdio != $past(mdio)))
      else $error("opcode is neither read nor write");
   chk_write_ta: assert property (frame_open ##1 op_write |-> ##11 mdio ##1 !mdio)
      else $error("write turnaround is not 10");
   chk_read_release: assert property (frame_open ##1 op_read |-> ##11 (!sta_mdio_oe && !phy_mdio_oe && mdio))
      else $error("first read turnaround bit is driven");
   chk_ta_zero: assert property ($rose(phy_mdio_oe) |-> !phy_mdio_out && !$past(sta_mdio_oe))
      else $error("device does not drive zero in second turnaround bit");
   chk_drive_on_read: assert property ($rose(phy_mdio_oe) |-> $past(mdio, 13) && !$past(mdio, 12))
      else $error("device drives after a non-read opcode");
   chk_drive_length: assert property ($fell(phy_mdio_oe) |-> drive_cnt == 5'h11)
      else $error("device drive burst is not seventeen bits");
endmodule : mgmt_link_chk

// ===== tb/phy_mgmt_serial_mmd_access_test.sv
// self-checking bench: avalon master on the station end, device end across the link
`timescale 1ns/1ps
module phy_mgmt_serial_mmd_access_test;
   localparam logic [4:0] WIN = mgmt_pkg::REG_ADDRESS_DATA;
   // clock, reset and straps
   logic clk = 1'b0;
   logic rst;
   logic [1:0] strap = 2'h0;
   // avalon master
   logic [1:0] address = 2'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic waitrequest;
   logic [1:0] station_id;
   // bench state
   int num_errors = 0;
   int checks = 0;
   int seed = 65320;
   logic [4:0] pa;
   logic [15:0] q, p, e;
   logic [15:0] dv[7];
   logic [15:0] ev[3];
   logic [15:0] m[4];
   logic [4:0] sels[3];
   logic [1:0] fns[3];

   mgmt_if link();
   mgmt_station_end mgmt_station_end_i(.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .bus(link.station));
   mgmt_phy_end mgmt_phy_end_i(.bus(link.phy), .rst(rst), .addr_strap(strap), .station_id(station_id));
   mgmt_link_chk mgmt_link_chk_i(.mdc(link.mdc), .rst(rst), .sta_mdio_out(link.sta_mdio_out),
      .sta_mdio_oe(link.sta_mdio_oe), .phy_mdio_out(link.phy_mdio_out), .phy_mdio_oe(link.phy_mdio_oe),
      .mdio(link.mdio));

   // 50 ns system clock
   always #25 clk = ~clk;

   task automatic finish_test();
      if (num_errors == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one avalon cycle; request held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge clk);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= ~wr;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      r = readdata;
      write <= 1'b0;
      read <= 1'b0;
      if (waitrequest !== 1'b0) begin
         num_errors++;
         $display("unexpected at %0t: waitrequest %h expected %h", $time, waitrequest, 1'b0);
         finish_test();
      end
   endtask : bus

   // one management frame, busy polled under a bound
   task automatic frame(input logic rd, input logic [4:0] pad, input logic [4:0] ra, input logic [15:0] wd,
      output logic [15:0] r);
      logic [31:0] s;
      int n;
      bus(1'b1, mgmt_pkg::CSR_WDATA, {16'h0000, wd}, s);
      bus(1'b1, mgmt_pkg::CSR_COMMAND, {19'h00000, rd, 2'h0, pad, ra}, s);
      n = 0;
      s = 32'h00000001;
      while (s[0] !== 1'b0 && n < 200) begin
         bus(1'b0, mgmt_pkg::CSR_STATUS, 32'h0, s);
         n++;
      end
      if (s[0] !== 1'b0) begin
         num_errors++;
         $display("unexpected at %0t: busy %h expected %h", $time, s[0], 1'b0);
         finish_test();
      end
      bus(1'b0, mgmt_pkg::CSR_RDATA, 32'h0, s);
      r = s[15:0];
   endtask : frame

   task automatic wr(input logic [4:0] ra, input logic [15:0] d);
      frame(1'b0, pa, ra, d, q);
   endtask : wr

   task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
      frame(1'b1, pa, ra, 16'h0000, q);
      chk(q, exp);
   endtask : rd

   task automatic ctl(input logic [1:0] fn, input logic [4:0] sel);
      wr(mgmt_pkg::REG_ACCESS_CONTROL, {fn, 9'h000, sel});
   endtask : ctl

   // pointer after one window access
   function automatic logic [15:0] next_ptr(input logic [1:0] fn, input logic is_wr, input logic [15:0] ptr);
      if (fn == mgmt_pkg::FN_DATA_INC_RW || (fn == mgmt_pkg::FN_DATA_INC_W && is_wr)) begin
         return ptr + 16'h0001;
      end
      return ptr;
   endfunction : next_ptr

   initial begin
      // a declaration value makes no edge, so the device end would never see its asynchronous reset
      rst <= 1'b1;
      strap <= 2'($random(seed));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      pa = {3'b000, strap};
      // direct registers spread over the map, last one included
      for (int i = 0; i < 7; i++) begin
         dv[i] = 16'($random(seed));
         wr(5'(i * 5 + 1), dv[i]);
      end
      chk({14'h0000, station_id}, {14'h0000, strap});
      frame(1'b0, pa ^ 5'h01, 5'h01, ~dv[0], q);
      frame(1'b1, pa ^ 5'h02, 5'h01, 16'h0000, q);
      chk(q, 16'hffff);
      for (int i = 0; i < 7; i++) begin
         rd(5'(i * 5 + 1), dv[i]);
      end
      // each space keeps its own word behind the same pointer
      sels = '{mgmt_pkg::SEL_VENDOR, mgmt_pkg::SEL_EEE3, mgmt_pkg::SEL_EEE7};
      p = 16'h0100 | (16'($random(seed)) & 16'h0007);
      for (int k = 0; k < 3; k++) begin
         ev[k] = 16'($random(seed));
         ctl(mgmt_pkg::FN_ADDRESS, sels[k]);
         wr(WIN, 16'($random(seed)));
         wr(WIN, p);
         rd(WIN, p);
         ctl(mgmt_pkg::FN_DATA, sels[k]);
         wr(WIN, ev[k]);
      end
      for (int k = 0; k < 3; k++) begin
         ctl(mgmt_pkg::FN_ADDRESS, sels[k]);
         wr(WIN, p);
         ctl(mgmt_pkg::FN_DATA, sels[k]);
         rd(WIN, ev[k]);
      end
      // unsupported selector touches neither pointer nor data
      ctl(mgmt_pkg::FN_ADDRESS, 5'h05);
      wr(WIN, 16'h0033);
      rd(WIN, 16'h0000);
      ctl(mgmt_pkg::FN_DATA, 5'h05);
      wr(WIN, 16'h0044);
      rd(WIN, 16'h0000);
      ctl(mgmt_pkg::FN_DATA, mgmt_pkg::SEL_EEE7);
      rd(WIN, ev[2]);
      // every data function: two writes, pointer, two reads, pointer
      fns = '{mgmt_pkg::FN_DATA, mgmt_pkg::FN_DATA_INC_RW, mgmt_pkg::FN_DATA_INC_W};
      for (int k = 0; k < 3; k++) begin
         ctl(mgmt_pkg::FN_ADDRESS, mgmt_pkg::SEL_VENDOR);
         wr(WIN, p);
         ctl(fns[k], mgmt_pkg::SEL_VENDOR);
         e = p;
         for (int j = 0; j < 2; j++) begin
            m[2'(e - p)] = 16'($random(seed));
            wr(WIN, m[2'(e - p)]);
            e = next_ptr(fns[k], 1'b1, e);
         end
         ctl(mgmt_pkg::FN_ADDRESS, mgmt_pkg::SEL_VENDOR);
         rd(WIN, e);
         wr(WIN, p);
         ctl(fns[k], mgmt_pkg::SEL_VENDOR);
         e = p;
         for (int j = 0; j < 2; j++) begin
            rd(WIN, m[2'(e - p)]);
            e = next_ptr(fns[k], 1'b0, e);
         end
         ctl(mgmt_pkg::FN_ADDRESS, mgmt_pkg::SEL_VENDOR);
         rd(WIN, e);
      end
      // the window cannot reach its own access control register
      ctl(mgmt_pkg::FN_ADDRESS, mgmt_pkg::SEL_VENDOR);
      wr(WIN, {11'h000, mgmt_pkg::REG_ACCESS_CONTROL});
      ctl(mgmt_pkg::FN_DATA, mgmt_pkg::SEL_VENDOR);
      wr(WIN, 16'h1234);
      rd(WIN, 16'h0000);
      rd(mgmt_pkg::REG_ACCESS_CONTROL, 16'h401f);
      // low vendor pointers reach the plain direct set through the window
      ctl(mgmt_pkg::FN_ADDRESS, mgmt_pkg::SEL_VENDOR);
      wr(WIN, 16'h0001);
      ctl(mgmt_pkg::FN_DATA, mgmt_pkg::SEL_VENDOR);
      rd(WIN, dv[0]);
      wr(WIN, ~dv[0]);
      rd(5'h01, ~dv[0]);
      finish_test();
   end
endmodule : phy_mgmt_serial_mmd_access_test

// ===== verilog/mgmt_if.sv
// two-party management link with pull-up resolution of the data wire
`timescale 1ns/1ps
interface mgmt_if;
   logic mdc;
   logic sta_mdio_out;
   logic sta_mdio_oe;
   logic phy_mdio_out;
   logic phy_mdio_oe;
   logic mdio;
   // released line floats high through the pull-up
   assign mdio = sta_mdio_oe ? sta_mdio_out : (phy_mdio_oe ? phy_mdio_out : 1'b1);
   modport station (output mdc, output sta_mdio_out, output sta_mdio_oe, input mdio);
   modport phy (input mdc, output phy_mdio_out, output phy_mdio_oe, input mdio);
endinterface : mgmt_if

// ===== verilog/mgmt_phy_end.sv
// device end: frame decoder, direct registers and indirect extended window
`timescale 1ns/1ps
module mgmt_phy_end #(
   parameter logic [2:0] ADDR_HIGH = 3'b000,
   parameter int EXT_AW = mgmt_pkg::EXT_AW_DEFAULT
) (
   // link side, clocked by the station's mdc
   mgmt_if.phy bus,
   // reset
   input wire logic rst,
   // straps and identity
   input wire logic [1:0] addr_strap,
   output logic [1:0] station_id
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_START = 3'b001,
      ST_HDR = 3'b011,
      ST_TA1 = 3'b010,
      ST_TA2 = 3'b110,
      ST_DATA = 3'b111
   } phase_e;

   phase_e phase;
   logic [3:0] bit_cnt;
   logic [10:0] hdr;
   logic [1:0] fr_op;
   logic [4:0] fr_reg;
   logic fr_hit;
   logic [15:0] wsh;
   logic [15:0] rsh;
   logic [1:0] strap_s1;
   logic [1:0] strap_s2;
   logic [1:0] settle_cnt;
   logic [15:0] access_control;
   logic [15:0] pointer;
   logic [15:0] dreg [mgmt_pkg::DIRECT_REGS];
   logic [15:0] emem [mgmt_pkg::EXT_SPACES][2**EXT_AW];
   logic [11:0] hdr_full;
   logic [4:0] sel;
   logic [1:0] fn;
   logic sel_ok;
   logic [1:0] space;
   logic vendor_direct;
   logic [15:0] ext_rd;
   logic [15:0] rd_val;
   logic frame_end;
   logic wr_done;
   logic rd_done;
   logic [15:0] wd;
   logic win_ok;

   // straps pass two flops, then are latched once the sync chain holds them
   always_ff @(posedge bus.mdc or posedge rst) begin
      if (rst) begin
         strap_s1 <= 2'b00;
         strap_s2 <= 2'b00;
      end else begin
         strap_s1 <= addr_strap;
         strap_s2 <= strap_s1;
      end
   end

   // latch taken after reset release, never under the reset itself
   always_ff @(posedge bus.mdc or posedge rst) begin
      if (rst) begin
         settle_cnt <= 2'b00;
         station_id <= 2'b00;
      end else if (settle_cnt != 2'(mgmt_pkg::STRAP_SETTLE + 1)) begin
         settle_cnt <= settle_cnt + 2'b01;
         if (settle_cnt == 2'(mgmt_pkg::STRAP_SETTLE)) begin
            station_id <= strap_s2;
         end
      end
   end

   // field views of the frame and of the access control register
   assign hdr_full = {hdr, bus.mdio};
   assign sel = access_control[mgmt_pkg::SEL_MSB:mgmt_pkg::SEL_LSB];
   assign fn = access_control[mgmt_pkg::FN_MSB:mgmt_pkg::FN_LSB];
   assign sel_ok = (sel == mgmt_pkg::SEL_VENDOR) || (sel == mgmt_pkg::SEL_EEE3) ||
                   (sel == mgmt_pkg::SEL_EEE7);
   assign space = (sel == mgmt_pkg::SEL_EEE3) ? 2'd1 : ((sel == mgmt_pkg::SEL_EEE7) ? 2'd2 : 2'd0);
   // low vendor addresses alias the direct set; the window pair itself is shut off
   assign vendor_direct = (sel == mgmt_pkg::SEL_VENDOR) && (pointer < 16'(mgmt_pkg::DIRECT_REGS));
   assign win_ok = sel_ok && !(vendor_direct && ((pointer[4:0] == mgmt_pkg::REG_ACCESS_CONTROL) ||
                   (pointer[4:0] == mgmt_pkg::REG_ADDRESS_DATA)));

   // read value of the extended register under the pointer
   always_comb begin
      if (vendor_direct) begin
         ext_rd = dreg[pointer[4:0]];
      end else begin
         ext_rd = emem[space][pointer[EXT_AW-1:0]];
      end
   end

   // read multiplexer over the direct set, window registers included
   always_comb begin
      case (fr_reg)
         mgmt_pkg::REG_ACCESS_CONTROL: rd_val = access_control;
         mgmt_pkg::REG_ADDRESS_DATA: begin
            if (!sel_ok) begin
               rd_val = 16'h0000;
            end else if (fn == mgmt_pkg::FN_ADDRESS) begin
               rd_val = pointer;
            end else if (win_ok) begin
               rd_val = ext_rd;
            end else begin
               rd_val = 16'h0000;
            end
         end
         default: rd_val = dreg[fr_reg];
      endcase
   end

   // completion events at the last data bit of a frame for this device
   assign frame_end = (phase == ST_DATA) && (bit_cnt == 4'(mgmt_pkg::DATA_BITS - 1)) && fr_hit;
   assign wr_done = frame_end && (fr_op == mgmt_pkg::OP_WRITE);
   assign rd_done = frame_end && (fr_op == mgmt_pkg::OP_READ);
   assign wd = {wsh[14:0], bus.mdio};

   // frame sequencer; all decisions on the rising clock edge
   always_ff @(posedge bus.mdc or posedge rst) begin
      if (rst) begin
         phase <= ST_IDLE;
         bit_cnt <= 4'h0;
         hdr <= 11'h000;
      end else begin
         case (phase)
            ST_IDLE: begin
               // stopped clock just freezes here, nothing times out
               if (!bus.mdio) begin
                  phase <= ST_START;
               end
            end
            ST_START: begin
               phase <= bus.mdio ? ST_HDR : ST_IDLE;
               bit_cnt <= 4'h0;
            end
            ST_HDR: begin
               hdr <= hdr_full[10:0];
               bit_cnt <= bit_cnt + 4'h1;
               if (bit_cnt == 4'(mgmt_pkg::HDR_BITS - 1)) begin
                  phase <= ST_TA1;
               end
            end
            ST_TA1: phase <= ST_TA2;
            ST_TA2: begin
               phase <= ST_DATA;
               bit_cnt <= 4'h0;
            end
            ST_DATA: begin
               bit_cnt <= bit_cnt + 4'h1;
               if (bit_cnt == 4'(mgmt_pkg::DATA_BITS - 1)) begin
                  phase <= ST_IDLE;
               end
            end
            default: phase <= ST_IDLE;
         endcase
      end
   end

   // header fields latched with the last register address bit, msb first
   always_ff @(posedge bus.mdc or posedge rst) begin
      if (rst) begin
         fr_op <= 2'b00;
         fr_reg <= 5'h00;
         fr_hit <= 1'b0;
      end else if (phase == ST_HDR && bit_cnt == 4'(mgmt_pkg::HDR_BITS - 1)) begin
         fr_op <= hdr_full[11:10];
         fr_reg <= hdr_full[4:0];
         fr_hit <= (hdr_full[9:5] == {ADDR_HIGH, station_id}) &&
                   (hdr_full[11:10] == mgmt_pkg::OP_READ || hdr_full[11:10] == mgmt_pkg::OP_WRITE);
      end
   end

   // write data shifts in; turnaround bits of a write are not checked
   always_ff @(posedge bus.mdc or posedge rst) begin
      if (rst) begin
         wsh <= 16'h0000;
      end else if (phase == ST_DATA) begin
         wsh <= wd;
      end
   end

   // line driver: quiet in the first turnaround bit, zero in the second, then data
   always_ff @(posedge bus.mdc or posedge rst) begin
      if (rst) begin
         bus.phy_mdio_oe <= 1'b0;
         bus.phy_mdio_out <= 1'b0;
         rsh <= 16'h0000;
      end else begin
         if (phase == ST_TA1 && fr_hit && fr_op == mgmt_pkg::OP_READ) begin
            bus.phy_mdio_oe <= 1'b1;
            bus.phy_mdio_out <= 1'b0;
         end else if (phase == ST_TA2 && bus.phy_mdio_oe) begin
            bus.phy_mdio_out <= rd_val[15];
            rsh <= {rd_val[14:0], 1'b0};
         end else if (phase == ST_DATA && bus.phy_mdio_oe) begin
            if (bit_cnt == 4'(mgmt_pkg::DATA_BITS - 1)) begin
               bus.phy_mdio_oe <= 1'b0;
               bus.phy_mdio_out <= 1'b0;
            end else begin
               bus.phy_mdio_out <= rsh[15];
               rsh <= {rsh[14:0], 1'b0};
            end
         end else if (phase == ST_IDLE) begin
            bus.phy_mdio_oe <= 1'b0;
         end
      end
   end

   // access control register and extended address pointer
   always_ff @(posedge bus.mdc or posedge rst) begin
      if (rst) begin
         access_control <= mgmt_pkg::ACCESS_CONTROL_RESET;
         pointer <= mgmt_pkg::POINTER_RESET;
      end else if (wr_done && fr_reg == mgmt_pkg::REG_ACCESS_CONTROL) begin
         access_control <= wd;
      end else if (wr_done && fr_reg == mgmt_pkg::REG_ADDRESS_DATA && sel_ok) begin
         if (fn == mgmt_pkg::FN_ADDRESS) begin
            pointer <= wd;
         end else if (fn == mgmt_pkg::FN_DATA_INC_RW || fn == mgmt_pkg::FN_DATA_INC_W) begin
            pointer <= pointer + 16'h0001;
         end
      end else if (rd_done && fr_reg == mgmt_pkg::REG_ADDRESS_DATA && sel_ok &&
                   fn == mgmt_pkg::FN_DATA_INC_RW) begin
         pointer <= pointer + 16'h0001;
      end
   end

   // register storage; an ignored window access writes nothing
   always_ff @(posedge bus.mdc or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < mgmt_pkg::DIRECT_REGS; i++) begin
            dreg[i] <= mgmt_pkg::REG_RESET;
         end
         for (int s = 0; s < mgmt_pkg::EXT_SPACES; s++) begin
            for (int j = 0; j < 2**EXT_AW; j++) begin
               emem[s][j] <= mgmt_pkg::REG_RESET;
            end
         end
      end else if (wr_done) begin
         if (fr_reg == mgmt_pkg::REG_ADDRESS_DATA) begin
            if (fn != mgmt_pkg::FN_ADDRESS && win_ok) begin
               if (vendor_direct) begin
                  dreg[pointer[4:0]] <= wd;
               end else begin
                  emem[space][pointer[EXT_AW-1:0]] <= wd;
               end
            end
         end else if (fr_reg != mgmt_pkg::REG_ACCESS_CONTROL) begin
            dreg[fr_reg] <= wd;
         end
      end
   end
endmodule : mgmt_phy_end

// ===== verilog/mgmt_pkg.sv
// shared constants for the serial management link, both ends
package mgmt_pkg;
   // clock and link timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int MDC_MAX_MHZ = 25;
   localparam int MDC_MIN_PERIOD_NS = 1000 / MDC_MAX_MHZ;
   localparam int MDC_HALF_MIN = ((MDC_MIN_PERIOD_NS / 2) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MDC_HALF_DEFAULT = (MDC_HALF_MIN > 4) ? MDC_HALF_MIN : 4;
   // frame layout as sent by the station: one idle bit, then 32 frame bits
   localparam int FRAME_BITS = 33;
   localparam int IDLE_BITS = 1;
   localparam int TA_FIRST = 15;
   localparam int HDR_BITS = 12;
   localparam int DATA_BITS = 16;
   localparam logic [1:0] START_CODE = 2'b01;
   localparam logic [1:0] OP_READ = 2'b10;
   localparam logic [1:0] OP_WRITE = 2'b01;
   localparam logic [1:0] TA_WRITE = 2'b10;
   // direct register map of the device
   localparam int DIRECT_REGS = 32;
   localparam logic [4:0] REG_ACCESS_CONTROL = 5'h0d;
   localparam logic [4:0] REG_ADDRESS_DATA = 5'h0e;
   localparam logic [15:0] ACCESS_CONTROL_RESET = 16'h0000;
   localparam logic [15:0] POINTER_RESET = 16'h0000;
   localparam logic [15:0] REG_RESET = 16'h0000;
   // access control fields
   localparam int SEL_LSB = 0;
   localparam int SEL_MSB = 4;
   localparam int FN_LSB = 14;
   localparam int FN_MSB = 15;
   localparam logic [4:0] SEL_VENDOR = 5'h1f;
   localparam logic [4:0] SEL_EEE3 = 5'h03;
   localparam logic [4:0] SEL_EEE7 = 5'h07;
   localparam logic [1:0] FN_ADDRESS = 2'b00;
   localparam logic [1:0] FN_DATA = 2'b01;
   localparam logic [1:0] FN_DATA_INC_RW = 2'b10;
   localparam logic [1:0] FN_DATA_INC_W = 2'b11;
   localparam int EXT_SPACES = 3;
   localparam int EXT_AW_DEFAULT = 4;
   // station register map on the avalon side (word addresses)
   localparam logic [1:0] CSR_COMMAND = 2'h0;
   localparam logic [1:0] CSR_WDATA = 2'h1;
   localparam logic [1:0] CSR_STATUS = 2'h2;
   localparam logic [1:0] CSR_RDATA = 2'h3;
   localparam int CMD_REG_LSB = 0;
   localparam int CMD_PHY_LSB = 5;
   localparam int CMD_READ_BIT = 12;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STRAP_SETTLE = 2;
endpackage : mgmt_pkg

// ===== verilog/mgmt_station_end.sv
// station end: avalon command registers, mdc divider and frame shifter
`timescale 1ns/1ps
module mgmt_station_end #(
   parameter int MDC_HALF = mgmt_pkg::MDC_HALF_DEFAULT
) (
   // system clock and reset
   input wire logic clk,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // link side
   mgmt_if.station bus
);
   localparam int BCW = $clog2(mgmt_pkg::FRAME_BITS + 1);
   localparam int HCW = $clog2(MDC_HALF + 1);

   logic busy;
   logic is_read;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic [15:0] rsh;
   logic [mgmt_pkg::FRAME_BITS-1:0] tx;
   logic [BCW-1:0] bit_idx;
   logic [HCW-1:0] half_cnt;
   logic mdio_s1;
   logic mdio_s2;
   logic take;
   logic start;
   logic half_end;

   // request accepted one cycle after it appears; waitrequest is a flop
   assign take = (read || write) && !waitrequest;
   assign start = take && write && address == mgmt_pkg::CSR_COMMAND && !busy;
   assign half_end = busy && (half_cnt == HCW'(MDC_HALF - 1));

   // avalon handshake and read data, valid at the accepting edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         waitrequest <= 1'b1;
         readdata <= 32'h00000000;
      end else begin
         waitrequest <= !((read || write) && waitrequest);
         if (read && waitrequest) begin
            case (address)
               mgmt_pkg::CSR_WDATA: readdata <= {16'h0000, wdata};
               mgmt_pkg::CSR_STATUS: readdata <= {31'h00000000, busy};
               mgmt_pkg::CSR_RDATA: readdata <= {16'h0000, rdata};
               default: readdata <= 32'h00000000;
            endcase
         end
      end
   end

   // write data register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wdata <= 16'h0000;
      end else if (take && write && address == mgmt_pkg::CSR_WDATA) begin
         wdata <= writedata[15:0];
      end
   end

   // returning line passes two flops before the shifter reads it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mdio_s1 <= 1'b1;
         mdio_s2 <= 1'b1;
      end else begin
         mdio_s1 <= bus.mdio;
         mdio_s2 <= mdio_s1;
      end
   end

   // mdc runs only during a frame and is parked low between frames
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         half_cnt <= '0;
         bus.mdc <= 1'b0;
      end else if (!busy) begin
         half_cnt <= '0;
         bus.mdc <= 1'b0;
      end else if (half_end) begin
         half_cnt <= '0;
         bus.mdc <= !bus.mdc;
      end else begin
         half_cnt <= half_cnt + HCW'(1);
      end
   end

   // frame shifter: changes the line on mdc fall, samples on mdc rise
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy <= 1'b0;
         is_read <= 1'b0;
         tx <= '0;
         bit_idx <= '0;
         rsh <= 16'h0000;
         rdata <= 16'h0000;
         bus.sta_mdio_oe <= 1'b0;
         bus.sta_mdio_out <= 1'b1;
      end else if (start) begin
         busy <= 1'b1;
         is_read <= writedata[mgmt_pkg::CMD_READ_BIT];
         // leading idle bit keeps the bus quiet one full mdc at the start of every frame
         tx <= {1'b1, mgmt_pkg::START_CODE,
                writedata[mgmt_pkg::CMD_READ_BIT] ? mgmt_pkg::OP_READ : mgmt_pkg::OP_WRITE,
                writedata[mgmt_pkg::CMD_PHY_LSB +: 5], writedata[mgmt_pkg::CMD_REG_LSB +: 5],
                mgmt_pkg::TA_WRITE, wdata};
         bit_idx <= '0;
         bus.sta_mdio_oe <= 1'b0;
         bus.sta_mdio_out <= 1'b1;
      end else if (half_end && !bus.mdc) begin
         if (is_read && bit_idx >= BCW'(mgmt_pkg::TA_FIRST + 2)) begin
            rsh <= {rsh[14:0], mdio_s2};
         end
      end else if (half_end && bus.mdc) begin
         if (bit_idx == BCW'(mgmt_pkg::FRAME_BITS - 1)) begin
            busy <= 1'b0;
            bus.sta_mdio_oe <= 1'b0;
            bus.sta_mdio_out <= 1'b1;
            if (is_read) begin
               rdata <= rsh;
            end
         end else begin
            bit_idx <= bit_idx + BCW'(1);
            tx <= {tx[mgmt_pkg::FRAME_BITS-2:0], 1'b0};
            bus.sta_mdio_out <= tx[mgmt_pkg::FRAME_BITS-2];
            // a read releases the line from the first turnaround bit on
            bus.sta_mdio_oe <= !(is_read && bit_idx + BCW'(1) >= BCW'(mgmt_pkg::TA_FIRST));
         end
      end
   end
endmodule : mgmt_station_end
